//--- logic/lsr_cfg.svh
// constants for the logical shift and rotate unit: offsets, fields, opcodes
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define LSR_OFS_OPERAND 8'h00
`define LSR_OFS_SOURCE2 8'h04
`define LSR_OFS_CMD 8'h08
`define LSR_OFS_RESULT 8'h0C
`define LSR_OFS_STATUS 8'h10

// ************************************************************
// field positions
// ************************************************************
`define LSR_CMD_OP_MSB 7
`define LSR_CMD_OP_LSB 0
`define LSR_CMD_CNT_MSB 11
`define LSR_CMD_CNT_LSB 8
`define LSR_CC_C 3
`define LSR_CC_V 2
`define LSR_CC_G 1
`define LSR_CC_L 0
`define LSR_STAT_ERR 8

// ************************************************************
// reset values
// ************************************************************
`define LSR_RST_WORD 32'h0000_0000
`define LSR_RST_CMD 12'h000
`define LSR_RST_CC 4'h0

// ************************************************************
// operation codes
// ************************************************************
`define LSR_OP_SHIFT_LEFT_WORD 8'hED
`define LSR_OP_SHIFT_LEFT_WORD_SHORT 8'h11
`define LSR_OP_SHIFT_RIGHT_WORD 8'hEC
`define LSR_OP_SHIFT_RIGHT_WORD_SHORT 8'h10
`define LSR_OP_SHIFT_LEFT_HALF 8'hCD
`define LSR_OP_SHIFT_LEFT_HALF_SHORT 8'h91
`define LSR_OP_SHIFT_RIGHT_HALF 8'hCC
`define LSR_OP_SHIFT_RIGHT_HALF_SHORT 8'h90
`define LSR_OP_ROTATE_LEFT_WORD 8'hEB
`define LSR_OP_ROTATE_RIGHT_WORD 8'hEA

`endif

//--- logic/lsr_pkg.sv
// types shared by the logical shift and rotate unit
package lsr_pkg;

	typedef enum logic [1:0] {
		LSR_ST_IDLE = 2'h0,
		LSR_ST_EXEC = 2'h1
	} lsr_state_t;

	typedef enum logic [2:0] {
		LSR_K_NONE = 3'h0,
		LSR_K_WL = 3'h1,
		LSR_K_WR = 3'h2,
		LSR_K_HL = 3'h3,
		LSR_K_HR = 3'h4,
		LSR_K_RL = 3'h5,
		LSR_K_RR = 3'h6
	} lsr_kind_t;

endpackage

//--- logic/lsr_shift_core.sv
// shift and end-around rotate of one operand with last-bit-out carry
`timescale 1ns/1ps
`default_nettype none
module lsr_shift_core #(
	parameter int W = 32,
	parameter int CW = 5
) (
	input wire logic [W-1:0] opnd, // value to shift
	input wire logic [CW-1:0] cnt, // places to move
	input wire logic left, // 1 moves toward the msb
	input wire logic rot, // 1 rotates end around
	output logic [W-1:0] res, // shifted value
	output logic carry // last bit moved out, 0 for zero count or rotate
);
	logic [W:0] lext;
	logic [W:0] rext;
	logic [2*W-1:0] rlw;
	logic [2*W-1:0] rrw;

	always_comb begin
		// one spare bit catches the last bit out, so no count test
		lext = {1'b0, opnd} << cnt;
		rext = {opnd, 1'b0} >> cnt;
		rlw = {opnd, opnd} << cnt;
		rrw = {opnd, opnd} >> cnt;
		if (rot) begin
			res = left ? rlw[2*W-1:W] : rrw[W-1:0];
			carry = 1'b0;
		end else if (left) begin
			res = lext[W-1:0];
			carry = lext[W];
		end else begin
			res = rext[W:1];
			carry = rext[0];
		end
	end
endmodule
`default_nettype wire

//--- logic/lsr_unit.sv
// logical shift and rotate unit with an apb register front end
`timescale 1ns/1ps
`default_nettype none
`include "lsr_cfg.svh"
module lsr_unit
	import lsr_pkg::*;
(
	input wire logic pclk, // unit clock
	input wire logic presetn, // async reset, active low
	input wire logic ce, // clock enable, low freezes all state
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, 1 writes
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	output logic wb_valid, // one-cycle pulse, result committed
	output logic [31:0] wb_data, // committed result
	output logic [3:0] wb_cc // committed flags c v g l
);
	// ************************************************************
	// apb slave
	// ************************************************************
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic access, hit, wr_fire, cmd_go;
	logic [31:0] rd_val;
	logic [31:0] opnd_r, opnd_nxt;
	logic [31:0] src2_r, src2_nxt;
	logic [11:0] cmd_r, cmd_nxt;
	lsr_state_t st_r, st_nxt;
	logic [31:0] result_r, result_nxt;
	logic [3:0] cc_r, cc_nxt;
	logic err_r, err_nxt;
	logic wbv_r, wbv_nxt;

	always_comb begin
		access = psel && penable;
		hit = (paddr[1:0] == 2'h0) && (paddr <= `LSR_OFS_STATUS);
		case (paddr)
			`LSR_OFS_OPERAND: rd_val = opnd_r;
			`LSR_OFS_SOURCE2: rd_val = src2_r;
			`LSR_OFS_CMD: rd_val = {20'h0_0000, cmd_r};
			`LSR_OFS_RESULT: rd_val = result_r;
			`LSR_OFS_STATUS: rd_val = {23'h00_0000, err_r, 4'h0, cc_r};
			default: rd_val = 32'h0000_0000;
		endcase
		// one wait state: ready rises in the second access cycle
		pready_nxt = access && !pready_r;
		pslverr_nxt = 1'b0;
		prdata_nxt = 32'h0000_0000;
		if (access && !pready_r) begin
			pslverr_nxt = !hit;
			prdata_nxt = pwrite ? 32'h0000_0000 : rd_val;
		end
		// writes land only on the edge that completes the transfer
		wr_fire = access && pready_r && pwrite && hit;
		cmd_go = wr_fire && (paddr == `LSR_OFS_CMD);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (ce) begin
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// ************************************************************
	// operand and command registers
	// ************************************************************
	always_comb begin
		opnd_nxt = opnd_r;
		src2_nxt = src2_r;
		cmd_nxt = cmd_r;
		if (wr_fire && paddr == `LSR_OFS_OPERAND) begin
			opnd_nxt = pwdata;
		end
		if (wr_fire && paddr == `LSR_OFS_SOURCE2) begin
			src2_nxt = pwdata;
		end
		if (cmd_go) begin
			cmd_nxt = pwdata[11:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opnd_r <= `LSR_RST_WORD;
			src2_r <= `LSR_RST_WORD;
			cmd_r <= `LSR_RST_CMD;
		end else if (ce) begin
			opnd_r <= opnd_nxt;
			src2_r <= src2_nxt;
			cmd_r <= cmd_nxt;
		end
	end

	// ************************************************************
	// decode and datapath
	// ************************************************************
	lsr_kind_t kind;
	logic [7:0] op;
	logic [3:0] short_cnt;
	logic [4:0] cnt;
	logic [31:0] w_res;
	logic [15:0] h_res;
	logic w_c, h_c, is_half, w_left, w_rot;
	logic [31:0] calc;
	logic calc_c;

	always_comb begin
		op = cmd_r[`LSR_CMD_OP_MSB:`LSR_CMD_OP_LSB];
		short_cnt = cmd_r[`LSR_CMD_CNT_MSB:`LSR_CMD_CNT_LSB];
		kind = LSR_K_NONE;
		cnt = src2_r[4:0];
		case (op)
			`LSR_OP_SHIFT_LEFT_WORD: kind = LSR_K_WL;
			`LSR_OP_SHIFT_RIGHT_WORD: kind = LSR_K_WR;
			`LSR_OP_ROTATE_LEFT_WORD: kind = LSR_K_RL;
			`LSR_OP_ROTATE_RIGHT_WORD: kind = LSR_K_RR;
			`LSR_OP_SHIFT_LEFT_WORD_SHORT: begin
				kind = LSR_K_WL;
				cnt = {1'b0, short_cnt};
			end
			`LSR_OP_SHIFT_RIGHT_WORD_SHORT: begin
				kind = LSR_K_WR;
				cnt = {1'b0, short_cnt};
			end
			`LSR_OP_SHIFT_LEFT_HALF: begin
				kind = LSR_K_HL;
				cnt = {1'b0, src2_r[3:0]};
			end
			`LSR_OP_SHIFT_RIGHT_HALF: begin
				kind = LSR_K_HR;
				cnt = {1'b0, src2_r[3:0]};
			end
			`LSR_OP_SHIFT_LEFT_HALF_SHORT: begin
				kind = LSR_K_HL;
				cnt = {1'b0, short_cnt};
			end
			`LSR_OP_SHIFT_RIGHT_HALF_SHORT: begin
				kind = LSR_K_HR;
				cnt = {1'b0, short_cnt};
			end
			default: kind = LSR_K_NONE;
		endcase
		is_half = (kind == LSR_K_HL) || (kind == LSR_K_HR);
		w_left = (kind == LSR_K_WL) || (kind == LSR_K_RL);
		w_rot = (kind == LSR_K_RL) || (kind == LSR_K_RR);
	end

	lsr_shift_core #(.W(32), .CW(5)) u_word (
		.opnd(opnd_r),
		.cnt(cnt),
		.left(w_left),
		.rot(w_rot),
		.res(w_res),
		.carry(w_c)
	);

	// only the low half moves, so a narrow core keeps its carry honest
	lsr_shift_core #(.W(16), .CW(4)) u_half (
		.opnd(opnd_r[15:0]),
		.cnt(cnt[3:0]),
		.left(kind == LSR_K_HL),
		.rot(1'b0),
		.res(h_res),
		.carry(h_c)
	);

	always_comb begin
		calc = is_half ? {opnd_r[31:16], h_res} : w_res;
		calc_c = is_half ? h_c : w_c;
	end

	// ************************************************************
	// execute and commit
	// ************************************************************
	always_comb begin
		st_nxt = st_r;
		result_nxt = result_r;
		cc_nxt = cc_r;
		err_nxt = err_r;
		wbv_nxt = 1'b0;
		case (st_r)
			LSR_ST_IDLE: begin
				if (cmd_go) begin
					st_nxt = LSR_ST_EXEC;
				end
			end
			LSR_ST_EXEC: begin
				st_nxt = LSR_ST_IDLE;
				if (kind == LSR_K_NONE) begin
					// unknown opcode leaves result and flags untouched
					err_nxt = 1'b1;
				end else begin
					err_nxt = 1'b0;
					wbv_nxt = 1'b1;
					result_nxt = calc;
					cc_nxt[`LSR_CC_C] = calc_c;
					cc_nxt[`LSR_CC_V] = 1'b0;
					if (is_half) begin
						cc_nxt[`LSR_CC_L] = calc[15];
						cc_nxt[`LSR_CC_G] = !calc[15] && |calc[15:0];
					end else begin
						cc_nxt[`LSR_CC_L] = calc[31];
						cc_nxt[`LSR_CC_G] = !calc[31] && |calc;
					end
				end
			end
			default: st_nxt = LSR_ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= LSR_ST_IDLE;
			result_r <= `LSR_RST_WORD;
			cc_r <= `LSR_RST_CC;
			err_r <= 1'b0;
			wbv_r <= 1'b0;
		end else if (ce) begin
			st_r <= st_nxt;
			result_r <= result_nxt;
			cc_r <= cc_nxt;
			err_r <= err_nxt;
			wbv_r <= wbv_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign wb_valid = wbv_r;
	assign wb_data = result_r;
	assign wb_cc = cc_r;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic ex;
	assign ex = (st_r == LSR_ST_EXEC) && ce;

	property p_word_left;
		ex && op == `LSR_OP_SHIFT_LEFT_WORD
			|=> result_r == ($past(opnd_r) << $past(src2_r[4:0]));
	endproperty
	a_word_left: assert property (p_word_left)
		else $error("word left shift result wrong");

	property p_word_right;
		ex && op == `LSR_OP_SHIFT_RIGHT_WORD
			|=> result_r == ($past(opnd_r) >> $past(src2_r[4:0]));
	endproperty
	a_word_right: assert property (p_word_right)
		else $error("word right shift result wrong");

	property p_carry_one;
		ex && kind == LSR_K_WL && cnt == 5'h01
			|=> cc_r[`LSR_CC_C] == $past(opnd_r[31]);
	endproperty
	a_carry_one: assert property (p_carry_one)
		else $error("carry is not the bit shifted out");

	property p_zero_cnt;
		ex && kind inside {LSR_K_WL, LSR_K_WR} && cnt == 5'h00
			|=> result_r == $past(opnd_r) && !cc_r[`LSR_CC_C];
	endproperty
	a_zero_cnt: assert property (p_zero_cnt)
		else $error("zero count shift altered value or carry");

	property p_word_flags;
		ex && !is_half && kind != LSR_K_NONE
			|=> !cc_r[`LSR_CC_V] && cc_r[`LSR_CC_L] == result_r[31]
			&& cc_r[`LSR_CC_G] == (!result_r[31] && result_r != 32'h0);
	endproperty
	a_word_flags: assert property (p_word_flags)
		else $error("word flags disagree with result");

	property p_half_left;
		ex && op == `LSR_OP_SHIFT_LEFT_HALF
			|=> result_r[31:16] == $past(opnd_r[31:16])
			&& result_r[15:0] == ($past(opnd_r[15:0]) << $past(src2_r[3:0]));
	endproperty
	a_half_left: assert property (p_half_left)
		else $error("half left shift result wrong");

	property p_half_short;
		ex && op == `LSR_OP_SHIFT_RIGHT_HALF_SHORT
			|=> result_r[31:16] == $past(opnd_r[31:16])
			&& result_r[15:0] == ($past(opnd_r[15:0]) >> $past(short_cnt));
	endproperty
	a_half_short: assert property (p_half_short)
		else $error("half right short shift result wrong");

	property p_half_flags;
		ex && is_half
			|=> cc_r[`LSR_CC_L] == result_r[15]
			&& cc_r[`LSR_CC_G] == (!result_r[15] && result_r[15:0] != 16'h0);
	endproperty
	a_half_flags: assert property (p_half_flags)
		else $error("half flags not from low half");

	property p_rotate;
		ex && w_rot
			|=> $countones(result_r) == $countones($past(opnd_r))
			&& !cc_r[`LSR_CC_C];
	endproperty
	a_rotate: assert property (p_rotate)
		else $error("rotate lost bits or set carry");

	property p_rot_one;
		ex && kind == LSR_K_RL && cnt == 5'h01
			|=> result_r == {$past(opnd_r[30:0]), $past(opnd_r[31])};
	endproperty
	a_rot_one: assert property (p_rot_one)
		else $error("rotate left by one wrong");

	property p_commit;
		$changed(result_r) |-> $past(st_r) == LSR_ST_EXEC && wb_valid;
	endproperty
	a_commit: assert property (p_commit)
		else $error("result changed outside a commit");

	c_carry: cover property (ex && kind == LSR_K_WL ##1 cc_r[`LSR_CC_C]);
	c_rot: cover property (ex && kind == LSR_K_RR ##1 cc_r[`LSR_CC_L]);
	c_half: cover property (ex && op == `LSR_OP_SHIFT_LEFT_HALF_SHORT);
	c_bad: cover property (ex && kind == LSR_K_NONE ##1 err_r);
endmodule
`default_nettype wire

//--- tb/lsr_regfile_model.sv
// register file write-back model standing beside the shift and rotate unit
`timescale 1ns/1ps
`default_nettype none
module lsr_regfile_model (
	input wire logic pclk, // unit clock
	input wire logic presetn, // async reset, active low
	input wire logic wb_valid, // write-back strobe
	input wire logic [31:0] wb_data, // result bound for the register
	input wire logic [3:0] wb_cc, // flags written with it
	output logic [31:0] reg_q, // copy of the first operand register
	output logic [3:0] cc_q, // copy of the condition code
	output int wr_cnt // write-backs seen
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_q <= 32'h0000_0000;
			cc_q <= 4'h0;
			wr_cnt <= 0;
		end else if (wb_valid) begin
			// register and flags land in one update, never apart
			reg_q <= wb_data;
			cc_q <= wb_cc;
			wr_cnt <= wr_cnt + 1;
		end
	end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the logical shift and rotate unit
`timescale 1ns/1ps
`default_nettype none
`include "lsr_cfg.svh"
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, wb_data, reg_q, rd, a, b, old;
	logic pready, pslverr, wb_valid, er;
	logic [3:0] wb_cc, cc_q, sc;
	logic [7:0] ops [10];
	int wr_cnt, w0;
	int miscompares = 0;
	int compares = 0;
	int cyc = 0;
	int seed = 32'h60C6;
	logic ce_drop = 1'b0;

	always #2 pclk = ~pclk;

	lsr_unit u_lsr_unit (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wb_valid(wb_valid), .wb_data(wb_data),
		.wb_cc(wb_cc));
	lsr_regfile_model u_lsr_regfile_model (.pclk(pclk), .presetn(presetn),
		.wb_valid(wb_valid), .wb_data(wb_data), .wb_cc(wb_cc),
		.reg_q(reg_q), .cc_q(cc_q), .wr_cnt(wr_cnt));

	// ********
	// checking and bus tasks
	// ********
	task automatic test_done();
		begin
			$display("compares %0d miscompares %0d", compares, miscompares);
			if (miscompares == 0 && compares > 0) begin
				$display("RESULT: PASS");
			end else begin
				$display("RESULT: FAIL");
			end
			$finish;
		end
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			compares++;
			if (got !== exp) begin
				miscompares++;
				$display("ERROR at %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask

	// response taken at the rising edge that sees pready, then released;
	// only the bench timeout ends a wait that never completes
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		begin
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= ad;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			do begin
				@(posedge pclk);
			end while (pready !== 1'b1);
			q = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			// freeze the unit right after a launching write lands
			if (ce_drop) begin
				ce <= 1'b0;
			end
			@(posedge pclk);
		end
	endtask

	// ********
	// reference model: returns {c, v, g, l, result}
	// ********
	function automatic logic [35:0] mdl(input logic [7:0] op,
		input logic [31:0] x, input logic [31:0] y, input logic [3:0] s);
		int n;
		logic [31:0] r;
		logic [15:0] h;
		logic c;
		logic hf;
		begin
			c = 1'b0;
			hf = 1'b0;
			r = x;
			h = x[15:0];
			n = y[4:0];
			case (op)
			`LSR_OP_SHIFT_LEFT_WORD_SHORT, `LSR_OP_SHIFT_RIGHT_WORD_SHORT,
			`LSR_OP_SHIFT_LEFT_HALF_SHORT, `LSR_OP_SHIFT_RIGHT_HALF_SHORT: n = s;
			`LSR_OP_SHIFT_LEFT_HALF, `LSR_OP_SHIFT_RIGHT_HALF: n = y[3:0];
			default: n = y[4:0];
			endcase
			case (op)
			`LSR_OP_SHIFT_LEFT_WORD, `LSR_OP_SHIFT_LEFT_WORD_SHORT: begin
				r = x << n;
				if (n != 0)
					c = x[32-n];
			end
			`LSR_OP_SHIFT_RIGHT_WORD, `LSR_OP_SHIFT_RIGHT_WORD_SHORT: begin
				r = x >> n;
				if (n != 0)
					c = x[n-1];
			end
			`LSR_OP_SHIFT_LEFT_HALF, `LSR_OP_SHIFT_LEFT_HALF_SHORT: begin
				h = x[15:0] << n;
				hf = 1'b1;
				if (n != 0)
					c = x[16-n];
			end
			`LSR_OP_SHIFT_RIGHT_HALF, `LSR_OP_SHIFT_RIGHT_HALF_SHORT: begin
				h = x[15:0] >> n;
				hf = 1'b1;
				if (n != 0)
					c = x[n-1];
			end
			`LSR_OP_ROTATE_LEFT_WORD: r = (x << n) | (x >> (32 - n));
			default: r = (x >> n) | (x << (32 - n));
			endcase
			if (hf) begin
				r = {x[31:16], h};
				return {c, 1'b0, h != 0 && !h[15], h[15], r};
			end
			return {c, 1'b0, r != 0 && !r[31], r[31], r};
		end
	endfunction

	task automatic run_op(input logic [7:0] op, input logic [31:0] x,
		input logic [31:0] y, input logic [3:0] s);
		logic [35:0] e;
		begin
			e = mdl(op, x, y, s);
			w0 = wr_cnt;
			apb(1'b1, `LSR_OFS_OPERAND, x, rd, er);
			apb(1'b1, `LSR_OFS_SOURCE2, y, rd, er);
			apb(1'b1, `LSR_OFS_CMD, {20'h0, s, op}, rd, er);
			do begin
				@(negedge pclk);
			end while (wb_valid !== 1'b1);
			chk(wb_data, e[31:0]);
			chk({28'h0, wb_cc}, {28'h0, e[35:32]});
			@(posedge pclk);
			apb(1'b0, `LSR_OFS_RESULT, 32'h0, rd, er);
			chk(rd, e[31:0]);
			apb(1'b0, `LSR_OFS_STATUS, 32'h0, rd, er);
			chk(rd, {28'h0, e[35:32]});
			chk(32'(wr_cnt - w0), 32'h1);
		end
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			test_done();
		end
	end

	// ********
	// main sequence
	// ********
	initial begin
		ops = '{`LSR_OP_SHIFT_LEFT_WORD, `LSR_OP_SHIFT_LEFT_WORD_SHORT,
			`LSR_OP_SHIFT_RIGHT_WORD, `LSR_OP_SHIFT_RIGHT_WORD_SHORT,
			`LSR_OP_SHIFT_LEFT_HALF, `LSR_OP_SHIFT_LEFT_HALF_SHORT,
			`LSR_OP_SHIFT_RIGHT_HALF, `LSR_OP_SHIFT_RIGHT_HALF_SHORT,
			`LSR_OP_ROTATE_LEFT_WORD, `LSR_OP_ROTATE_RIGHT_WORD};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		ce <= 1'b1;
		@(posedge pclk);
		run_op(`LSR_OP_ROTATE_LEFT_WORD, 32'h5678_9ABC, 32'h4, 4'h0);
		chk(reg_q, 32'h6789_ABC5);
		run_op(`LSR_OP_ROTATE_LEFT_WORD, 32'h8888_0000, 32'h3, 4'h0);
		chk(reg_q, 32'h4440_0004);
		run_op(`LSR_OP_ROTATE_RIGHT_WORD, 32'h1234_5678, 32'h4, 4'h0);
		chk(reg_q, 32'h8123_4567);
		chk({28'h0, cc_q}, 32'h1);
		$display("test examples done");
		// an undefined opcode must leave result and write-back alone and set the error bit
		old = reg_q;
		w0 = wr_cnt;
		apb(1'b1, `LSR_OFS_CMD, 32'h0000_0000, rd, er);
		repeat (4) @(posedge pclk);
		chk(32'(wr_cnt - w0), 32'h0);
		apb(1'b0, `LSR_OFS_STATUS, 32'h0, rd, er);
		chk({31'h0, rd[8]}, 32'h1);
		apb(1'b1, `LSR_OFS_RESULT, 32'hFFFF_FFFF, rd, er);
		apb(1'b0, `LSR_OFS_RESULT, 32'h0, rd, er);
		chk(rd, old);
		apb(1'b0, `LSR_OFS_OPERAND, 32'h0, rd, er);
		chk(rd, 32'h1234_5678);
		apb(1'b0, 8'h14, 32'h0, rd, er);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b0, 8'h02, 32'h0, rd, er);
		chk({31'h0, er}, 32'h1);
		$display("test refusals done");
		// a low clock enable must hold a launched command in execute
		old = wb_data;
		w0 = wr_cnt;
		apb(1'b1, `LSR_OFS_OPERAND, 32'h0000_00F0, rd, er);
		apb(1'b1, `LSR_OFS_SOURCE2, 32'h0000_0004, rd, er);
		ce_drop = 1'b1;
		apb(1'b1, `LSR_OFS_CMD, {24'h00_0000, `LSR_OP_SHIFT_LEFT_WORD}, rd, er);
		ce_drop = 1'b0;
		repeat (4) @(posedge pclk);
		chk({31'h0, wb_valid}, 32'h0);
		chk(32'(wr_cnt - w0), 32'h0);
		chk(wb_data, old);
		ce <= 1'b1;
		do begin
			@(negedge pclk);
		end while (wb_valid !== 1'b1);
		chk(wb_data, 32'h0000_0F00);
		chk({28'h0, wb_cc}, 32'h2);
		repeat (2) @(posedge pclk);
		chk(32'(wr_cnt - w0), 32'h1);
		$display("test clock enable done");
		// reset in mid-run clears every committed output
		presetn <= 1'b0;
		@(posedge pclk);
		chk(wb_data, 32'h0);
		chk({28'h0, wb_cc}, 32'h0);
		chk({31'h0, wb_valid}, 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		$display("test reset done");
		for (int i = 0; i < 10; i++) begin
			for (int k = 0; k < 6; k++) begin
				a = $random(seed);
				b = $random(seed);
				sc = b[11:8];
				if (k == 0) begin
					b[4:0] = 5'h00;
					sc = 4'h0;
				end
				if (k == 1) begin
					b[4:0] = 5'h1F;
					sc = 4'hF;
				end
				if (k == 2)
					a[15:0] = 16'h0000;
				if (k == 3)
					a = 32'h0000_0000;
				run_op(ops[i], a, b, sc);
			end
			$display("test opcode %h done", ops[i]);
		end
		test_done();
	end
endmodule
`default_nettype wire
